// *** core/gated_timer_pkg.sv ***
// Package of constants and types for the gated sixteen bit timer.
package gated_timer_pkg;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [2:0]  PRESCALE_RESET = 3'h0;
   localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
   localparam logic [1:0]  CS_INSTR       = 2'h0;
   localparam logic [1:0]  CS_SYSTEM      = 2'h1;
   localparam logic [1:0]  CS_EXTERNAL    = 2'h2;
   localparam logic [1:0]  CS_CAPSENSE    = 2'h3;
   localparam logic [2:0]  SYNC_STAGES    = 3'h2;

   typedef enum logic [1:0] {
      ARM_WAIT_FALL = 2'b00,
      ARM_READY     = 2'b01
   } arm_state_e;

   typedef struct packed {
      logic [15:0] count;
      logic [2:0]  prescale;
      logic [1:0]  instr_div;
      logic        sync1;
      logic        sync2;
      logic        src_prev;
      arm_state_e  arm;
      logic        timer_on_prev;
      logic        overflow;
   } timer_state_s;
endpackage

// *** core/gated_sixteen_bit_timer.sv ***
// Sixteen bit gated timer/counter with clock selection and prescaler.
`timescale 1ns/10ps
module gated_sixteen_bit_timer
   import gated_timer_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   // Control bits.
   input  wire logic       timer_on_in,
   input  wire logic       gate_enable_in,
   input  wire logic       gate_polarity_in,
   input  wire logic [1:0] clock_select_in,
   input  wire logic       crystal_osc_enable_in,
   input  wire logic [1:0] prescale_select_in,
   input  wire logic       sync_disable_in,
   input  wire logic       sleep_in,
   // Count byte writes.
   input  wire logic       write_low_in,
   input  wire logic       write_high_in,
   input  wire logic [7:0] write_data_in,
   input  wire logic       overflow_clear_in,
   // Pins.
   input  wire logic       ext_clock_pin_in,
   input  wire logic       crystal_in_pin_in,
   input  wire logic       capsense_osc_in,
   input  wire logic       gate_in,
   // Outputs.
   output logic [7:0]      count_low_byte_out,
   output logic [7:0]      count_high_byte_out,
   output logic            overflow_flag_out,
   output logic            crystal_out_pin_out,
   output logic            wake_out
);
   timer_state_s s_q;
   timer_state_s s_d;
   logic         ext_src;
   logic         src_now;
   logic         gate_ok;
   logic         run;
   logic         tick;
   logic         ext_mode;
   logic         pre_hit;
   logic         wr;

   // Source mux: crystal amplifier only drives while enabled, even in sleep.
   always_comb begin
      crystal_out_pin_out = crystal_osc_enable_in & ~crystal_in_pin_in;
      ext_src = crystal_osc_enable_in ? crystal_in_pin_in : ext_clock_pin_in;
      if (clock_select_in == CS_CAPSENSE) begin
         ext_src = capsense_osc_in;
      end
   end

   // Main next-state logic.
   always_comb begin
      s_d = s_q;
      ext_mode = clock_select_in[1];
      wr = write_low_in | write_high_in;
      // Synchroniser: sync1 feeds sync2, and feeds the edge detector directly while sync_disable_in is set.
      s_d.sync1 = ext_src;
      s_d.sync2 = s_q.sync1;
      // Bypassing the second stage models asynchronous operation; a switch may
      // thus lose or gain one edge.
      src_now = sync_disable_in ? s_q.sync1 : s_q.sync2;
      s_d.src_prev = src_now;
      s_d.timer_on_prev = timer_on_in;
      gate_ok = (gate_in == gate_polarity_in);
      run = timer_on_in & (~gate_enable_in | gate_ok);
      // Sleep halts all but asynchronous external and capsense counting.
      if (sleep_in & ~(ext_mode & sync_disable_in)) begin
         run = 1'b0;
      end
      s_d.instr_div = s_q.instr_div + 2'h1;
      tick = 1'b0;
      case (clock_select_in)
         CS_SYSTEM:   tick = 1'b1;
         CS_INSTR:    tick = (s_q.instr_div == INSTR_DIV_LAST);
         CS_EXTERNAL,
         CS_CAPSENSE: tick = src_now & ~s_q.src_prev & (s_q.arm == ARM_READY);
         default:     tick = 1'b0;
      endcase
      // Arming needs a falling edge after enable or a count write.
      if (wr | (timer_on_in & ~s_q.timer_on_prev)) begin
         s_d.arm = ARM_WAIT_FALL;
      end else if (~src_now & s_q.src_prev) begin
         s_d.arm = ARM_READY;
      end
      pre_hit = 1'b0;
      if (run & tick) begin
         case (prescale_select_in)
            2'h0:    pre_hit = 1'b1;
            2'h1:    pre_hit = s_q.prescale[0];
            2'h2:    pre_hit = &s_q.prescale[1:0];
            default: pre_hit = &s_q.prescale;
         endcase
         s_d.prescale = pre_hit ? PRESCALE_RESET : s_q.prescale + 3'h1;
      end
      if (pre_hit) begin
         s_d.count = s_q.count + 16'h0001;
         if (s_q.count == COUNT_MAX) begin
            s_d.overflow = 1'b1;
         end
      end
      if (overflow_clear_in & ~(pre_hit & (s_q.count == COUNT_MAX))) begin
         s_d.overflow = 1'b0;
      end
      // Written bytes win over a coincident increment, and any write clears the prescaler.
      if (write_low_in) begin
         s_d.count[7:0] = write_data_in;
      end
      if (write_high_in) begin
         s_d.count[15:8] = write_data_in;
      end
      if (wr) begin
         s_d.prescale = PRESCALE_RESET;
      end
   end

   // State register.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_q <= '{count: COUNT_RESET, prescale: PRESCALE_RESET, instr_div: 2'h0,
                  sync1: 1'b0, sync2: 1'b0, src_prev: 1'b0, arm: ARM_WAIT_FALL,
                  timer_on_prev: 1'b0, overflow: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Byte reads come straight from the count register, always coherent.
   assign count_low_byte_out  = s_q.count[7:0];
   assign count_high_byte_out = s_q.count[15:8];
   assign overflow_flag_out   = s_q.overflow;
   assign wake_out            = s_q.overflow & sleep_in;

   // Assertions.
   chk_wrap_sets_flag: assert property (@(posedge clk_in) disable iff (reset_in)
      (pre_hit && s_q.count == COUNT_MAX && !wr) |=> (s_q.count == COUNT_RESET && s_q.overflow))
      else $error("Wrap did not set overflow.");
   chk_off_holds_count: assert property (@(posedge clk_in) disable iff (reset_in)
      (!timer_on_in && !wr) |=> $stable(s_q.count))
      else $error("Count moved while timer off.");
   chk_gate_blocks_count: assert property (@(posedge clk_in) disable iff (reset_in)
      (gate_enable_in && gate_in != gate_polarity_in && !wr) |=> $stable(s_q.count))
      else $error("Count moved while gate closed.");
   chk_write_low_byte: assert property (@(posedge clk_in) disable iff (reset_in)
      write_low_in |=> (count_low_byte_out == $past(write_data_in)))
      else $error("Low byte write lost.");
   chk_write_clears_pre: assert property (@(posedge clk_in) disable iff (reset_in)
      wr |=> (s_q.prescale == PRESCALE_RESET))
      else $error("Prescaler not cleared by write.");
   sequence free_system_run;
      (timer_on_in && !gate_enable_in && !sleep_in && !wr && !overflow_clear_in
       && clock_select_in == CS_SYSTEM && prescale_select_in == 2'h0)[*4];
   endsequence
   chk_system_adds_four: assert property (@(posedge clk_in) disable iff (reset_in)
      free_system_run |=> (s_q.count == $past(s_q.count, 4) + 16'h0004))
      else $error("System clock did not add four per instruction.");
   chk_prescale_one_hit: assert property (@(posedge clk_in) disable iff (reset_in)
      (run && tick && prescale_select_in == 2'h0) |-> pre_hit)
      else $error("Divide by one missed an increment.");
   chk_fall_before_count: assert property (@(posedge clk_in) disable iff (reset_in)
      (ext_mode && s_q.arm == ARM_WAIT_FALL) |-> !tick)
      else $error("External count before falling edge.");

   // Reset puts the count and the overflow flag back to zero.
   chk_reset_clears_state: assert property (@(posedge clk_in)
      reset_in |=> (s_q.count == COUNT_RESET && !s_q.overflow))
      else $error("Reset did not clear the count.");

   // A high byte write lands in the next cycle and beats an increment.
   chk_write_high_byte: assert property (@(posedge clk_in) disable iff (reset_in)
      write_high_in |=> (count_high_byte_out == $past(write_data_in)))
      else $error("High byte write lost.");

   // Without a write the count moves by one at most per clock.
   chk_count_single_step: assert property (@(posedge clk_in) disable iff (reset_in)
      !wr |=> (s_q.count == $past(s_q.count) || s_q.count == $past(s_q.count) + 16'h0001))
      else $error("Count jumped by more than one.");

   // Sleep freezes every source but the asynchronous external and capsense ones.
   chk_sleep_holds_count: assert property (@(posedge clk_in) disable iff (reset_in)
      (sleep_in && !(ext_mode && sync_disable_in) && !wr) |=> $stable(s_q.count))
      else $error("Count moved in sleep.");

   // The overflow flag stays set until software clears it.
   chk_flag_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
      (s_q.overflow && !overflow_clear_in) |=> s_q.overflow)
      else $error("Overflow flag dropped by itself.");

   // A clear with no coincident wrap drops the flag.
   chk_clear_drops_flag: assert property (@(posedge clk_in) disable iff (reset_in)
      (overflow_clear_in && !(pre_hit && s_q.count == COUNT_MAX)) |=> !s_q.overflow)
      else $error("Overflow clear ignored.");

   // A wrap in the cycle of a clear still leaves the flag set.
   chk_set_beats_clear: assert property (@(posedge clk_in) disable iff (reset_in)
      (overflow_clear_in && pre_hit && s_q.count == COUNT_MAX) |=> s_q.overflow)
      else $error("Clear beat a coincident wrap.");

   // Uninterrupted system clock runs at divide by two, four and eight.
   sequence half_rate_run;
      (run && clock_select_in == CS_SYSTEM && prescale_select_in == 2'h1 && !wr)[*2];
   endsequence

   sequence quarter_rate_run;
      (run && clock_select_in == CS_SYSTEM && prescale_select_in == 2'h2 && !wr)[*4];
   endsequence

   sequence eighth_rate_run;
      (run && clock_select_in == CS_SYSTEM && prescale_select_in == 2'h3 && !wr)[*8];
   endsequence

   // Uninterrupted instruction clock run without division.
   sequence instr_run;
      (run && clock_select_in == CS_INSTR && prescale_select_in == 2'h0 && !wr)[*4];
   endsequence

   // Two ticks under divide by two give exactly one increment.
   chk_divide_by_two: assert property (@(posedge clk_in) disable iff (reset_in)
      half_rate_run |=> (s_q.count == $past(s_q.count, 2) + 16'h0001))
      else $error("Divide by two rate wrong.");

   // Four ticks under divide by four give exactly one increment.
   chk_divide_by_four: assert property (@(posedge clk_in) disable iff (reset_in)
      quarter_rate_run |=> (s_q.count == $past(s_q.count, 4) + 16'h0001))
      else $error("Divide by four rate wrong.");

   // Eight ticks under divide by eight give exactly one increment.
   chk_divide_by_eight: assert property (@(posedge clk_in) disable iff (reset_in)
      eighth_rate_run |=> (s_q.count == $past(s_q.count, 8) + 16'h0001))
      else $error("Divide by eight rate wrong.");

   // The instruction clock adds one every four system clocks.
   chk_instr_quarter: assert property (@(posedge clk_in) disable iff (reset_in)
      instr_run |=> (s_q.count == $past(s_q.count, 4) + 16'h0001))
      else $error("Instruction clock rate wrong.");

   // An open gate lets every system clock through.
   chk_gate_open_counts: assert property (@(posedge clk_in) disable iff (reset_in)
      (run && gate_enable_in && clock_select_in == CS_SYSTEM && prescale_select_in == 2'h0
       && !wr) |=> (s_q.count == $past(s_q.count) + 16'h0001))
      else $error("Open gate missed an increment.");

   // Turning the timer on disarms the external edge detector.
   chk_enable_rearms: assert property (@(posedge clk_in) disable iff (reset_in)
      (timer_on_in && !s_q.timer_on_prev) |=> (s_q.arm == ARM_WAIT_FALL))
      else $error("Enable did not disarm.");

   // A count write disarms the external edge detector.
   chk_write_rearms: assert property (@(posedge clk_in) disable iff (reset_in)
      wr |=> (s_q.arm == ARM_WAIT_FALL))
      else $error("Write did not disarm.");

   // A falling edge with nothing else pending arms the detector.
   sequence falling_edge_seen;
      !src_now && s_q.src_prev && !wr && !(timer_on_in && !s_q.timer_on_prev);
   endsequence
   chk_fall_arms: assert property (@(posedge clk_in) disable iff (reset_in)
      falling_edge_seen |=> (s_q.arm == ARM_READY))
      else $error("Falling edge did not arm.");

   // An armed rising edge adds one when undivided.
   chk_ext_rise_counts: assert property (@(posedge clk_in) disable iff (reset_in)
      (run && ext_mode && s_q.arm == ARM_READY && src_now && !s_q.src_prev
       && prescale_select_in == 2'h0 && !wr) |=> (s_q.count == $past(s_q.count) + 16'h0001))
      else $error("External rising edge lost.");

   // No rising edge on an external source, no increment.
   chk_ext_idle_holds: assert property (@(posedge clk_in) disable iff (reset_in)
      (ext_mode && !(src_now && !s_q.src_prev) && !wr) |=> $stable(s_q.count))
      else $error("External count without rising edge.");

   // The second synchroniser stage follows the first.
   chk_sync_second_stage: assert property (@(posedge clk_in) disable iff (reset_in)
      1'b1 |=> (s_q.sync2 == $past(s_q.sync1)))
      else $error("Synchroniser stage skipped.");

   // The crystal amplifier is quiet while disabled.
   chk_crystal_idle_off: assert property (@(posedge clk_in) disable iff (reset_in)
      !crystal_osc_enable_in |-> !crystal_out_pin_out)
      else $error("Crystal driven while disabled.");

   // A pending overflow in sleep raises the wake line.
   chk_wake_on_flag: assert property (@(posedge clk_in) disable iff (reset_in)
      (s_q.overflow && sleep_in) |-> wake_out)
      else $error("Overflow did not wake.");

   // The prescaler is frozen while the timer is off.
   chk_off_holds_pre: assert property (@(posedge clk_in) disable iff (reset_in)
      (!timer_on_in && !wr) |=> $stable(s_q.prescale))
      else $error("Prescaler moved while timer off.");
endmodule // gated_sixteen_bit_timer

// *** tb/ext_clock_source.sv ***
// Model of the external clock sources that feed the timer.
`timescale 1ns/10ps
module ext_clock_source (
   // Clock.
   input  wire logic clk_in,
   // Source lines.
   output logic      ext_clock_pin_out,
   output logic      crystal_pin_out,
   output logic      capsense_osc_out
);
   logic [2:0] lines = 3'h0;
   // Lines rest low between bursts, so a burst always opens with a rise.
   assign {capsense_osc_out, crystal_pin_out, ext_clock_pin_out} = lines;
   // Sends n full cycles on one line, each level held half clock periods.
   task pulses(input int sel, input int n, input int half);
      for (int i = 0; i < n; i++) begin
         lines[sel] = 1'b1;
         repeat (half) @(posedge clk_in);
         #1 lines[sel] = 1'b0;
         repeat (half) @(posedge clk_in);
         #1;
      end
   endtask
endmodule // ext_clock_source

// *** tb/gated_sixteen_bit_timer_test.sv ***
// Self-checking bench for the gated sixteen bit timer.
`timescale 1ns/10ps
module gated_sixteen_bit_timer_test;
   import gated_timer_pkg::*;
   logic        clk_in = 1'b0, reset_in = 1'b1, on = 1'b0, g_en = 1'b0, g_pol = 1'b0, gate = 1'b0;
   logic        x_en = 1'b0, s_dis = 1'b0, sleep = 1'b0, wr_lo = 1'b0, wr_hi = 1'b0, o_clr = 1'b0;
   logic [1:0]  csel = 2'h0, psel = 2'h0;
   logic [7:0]  wdata = 8'h00, lo, hi;
   logic        ovf, x_out, wake, pin, xtal, cap;
   logic [15:0] base;
   int          error_cnt = 0, total_checks = 0;
   gated_sixteen_bit_timer gated_sixteen_bit_timer_i (.clk_in(clk_in), .reset_in(reset_in),
      .timer_on_in(on), .gate_enable_in(g_en), .gate_polarity_in(g_pol), .clock_select_in(csel),
      .crystal_osc_enable_in(x_en), .prescale_select_in(psel), .sync_disable_in(s_dis),
      .sleep_in(sleep), .write_low_in(wr_lo), .write_high_in(wr_hi), .write_data_in(wdata),
      .overflow_clear_in(o_clr), .ext_clock_pin_in(pin), .crystal_in_pin_in(xtal),
      .capsense_osc_in(cap), .gate_in(gate), .count_low_byte_out(lo), .count_high_byte_out(hi),
      .overflow_flag_out(ovf), .crystal_out_pin_out(x_out), .wake_out(wake));
   ext_clock_source ext_clock_source_i (.clk_in(clk_in), .ext_clock_pin_out(pin),
      .crystal_pin_out(xtal), .capsense_osc_out(cap));
   // Clock of 100 ns period.
   always #50 clk_in = ~clk_in;
   // Waits n edges, then steps 1 ns past the last one.
   task step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   function logic [15:0] cnt();
      return {hi, lo};
   endfunction
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Writes the low byte, then the high byte, and lets the last write land.
   task wr(input logic [15:0] v);
      wdata = v[7:0];
      wr_lo = 1'b1;
      step(1);
      wr_lo = 1'b0;
      wdata = v[15:8];
      wr_hi = 1'b1;
      step(1);
      wr_hi = 1'b0;
      step(1);
   endtask
   task clr_flag();
      o_clr = 1'b1;
      step(1);
      o_clr = 1'b0;
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #3000000 error_cnt++;
      test_done();
   end
   // Main sequence.
   initial begin
      step(6);
      reset_in = 1'b0;
      step(1);
      chk("reset count", 16'h0000, cnt());
      wr(16'hA55A);
      chk("written count", 16'hA55A, cnt());
      csel = CS_SYSTEM;
      step(8);
      chk("off count", 16'hA55A, cnt());
      $display("write and off test done");
      on = 1'b1;
      for (int p = 0; p < 4; p++) begin
         psel = p[1:0];
         wr(16'h0000);
         base = cnt();
         step(16);
         chk("system rate", base + (16'h0010 >> p), cnt());
      end
      csel = CS_INSTR;
      psel = 2'h0;
      step(4);
      base = cnt();
      step(16);
      chk("instr rate", base + 16'h0004, cnt());
      csel = CS_SYSTEM;
      g_en = 1'b1;
      gate = 1'b1;
      step(4);
      base = cnt();
      step(8);
      chk("gate closed", base, cnt());
      g_pol = 1'b1;
      step(4);
      base = cnt();
      step(8);
      chk("gate open", base + 16'h0008, cnt());
      $display("rate and gate test done");
      {on, g_en} = 2'b00;
      clr_flag();
      wr(16'hFFFE);
      on = 1'b1;
      for (int i = 0; i < 20 && ovf !== 1'b1; i++) step(1);
      on = 1'b0;
      chk("overflow flag", 16'h0001, {15'h0000, ovf});
      chk("wrapped", 16'h0001, {15'h0000, cnt() < 16'h0008});
      csel = CS_EXTERNAL;
      wr(16'h0000);
      on = 1'b1;
      ext_clock_source_i.pulses(0, 5, 3);
      step(4);
      chk("pin count", 16'h0004, cnt());
      on = 1'b0;
      s_dis = 1'b1;
      clr_flag();
      chk("flag cleared", 16'h0000, {15'h0000, ovf});
      wr(16'hFFFE);
      {on, sleep} = 2'b11;
      ext_clock_source_i.pulses(0, 4, 3);
      step(4);
      chk("sleep wake", 16'h0001, {15'h0000, wake});
      {on, sleep, s_dis} = 3'b000;
      csel = CS_CAPSENSE;
      wr(16'h0000);
      on = 1'b1;
      ext_clock_source_i.pulses(2, 3, 3);
      step(4);
      chk("capsense count", 16'h0002, cnt());
      $display("external source test done");
      on = 1'b0;
      csel = CS_EXTERNAL;
      x_en = 1'b1;
      step(20);
      chk("crystal drive", 16'h0001, {15'h0000, x_out});
      wr(16'h0000);
      on = 1'b1;
      ext_clock_source_i.pulses(1, 3, 3);
      step(4);
      chk("crystal count", 16'h0002, cnt());
      $display("crystal test done");
      test_done();
   end
endmodule // gated_sixteen_bit_timer_test
